// file: core/motion_command_defs.svh
// Constants for the command frame receiver and reply sender.
// Assumes one 100 MHz clock; byte positions are shared by serial and CAN frames.
`ifndef MOTION_COMMAND_DEFS_SVH
`define MOTION_COMMAND_DEFS_SVH

`define POS_ADDR        4'h0
`define POS_CMD         4'h1
`define POS_TYPE        4'h2
`define POS_BANK        4'h3
`define POS_VAL_FIRST   4'h4
`define POS_VAL_SECOND  4'h5
`define POS_VAL_THIRD   4'h6
`define POS_VAL_LAST    4'h7
`define POS_CHK         4'h8
`define POS_REP_STATUS  4'h2

`define CLK_PERIOD_NS   32'h0000_000A
`define IDLE_TIMEOUT_NS 32'h000F_4240
`define PROG_DEPTH_DEF  16
`define FIFO_DEPTH_DEF  16

`endif

// file: core/motion_command_pkg.sv
// Types for the command frame receiver.
// Assumes the constants header is included by the files that need it.
package motion_command_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [10:0] can_id_t;
  localparam int FIFO_W = $bits(can_id_t) + $bits(byte_t);

  typedef enum logic [7:0] {
    ST_BAD_CHECKSUM = 8'h01,
    ST_BAD_COMMAND  = 8'h02,
    ST_BAD_TYPE     = 8'h03,
    ST_BAD_VALUE    = 8'h04,
    ST_OK           = 8'h64,
    ST_STORED       = 8'h65
  } status_e;

  typedef enum logic [3:0] {
    S_RECV  = 4'b0001,
    S_EXEC  = 4'b0010,
    S_REPLY = 4'b0100,
    S_RUN   = 4'b1000
  } state_e;
endpackage : motion_command_pkg

// file: core/byte_stream_if.sv
// Valid/ready word stream between the receiver and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// file: core/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rstN,
  // Fill and drain sides
  byte_stream_if.snk  wr,
  byte_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [AW:0]   count_ff, nxt_count;
  logic          push, pop;

  // Full and empty come straight from the count, so ready is honest
  assign wr.ready = (count_ff != (AW+1)'(DEPTH));
  assign rd.valid = (count_ff != '0);
  assign rd.data  = mem[rdPtr_ff];

  always_comb begin
    push      = wr.valid && wr.ready;
    pop       = rd.valid && rd.ready;
    nxt_wrPtr = push ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
    nxt_rdPtr = pop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = (AW+1)'(count_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_count = (AW+1)'(count_ff - 1'b1);
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // Storage needs no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_ff] <= wr.data;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// file: core/motion_command_frame_parser.sv
// Command frame receiver, stored-program sequencer and reply sender.
// Assumes bytes come from a line receiver on the same clock, and an executor
// that answers each command with one done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "motion_command_defs.svh"
module motion_command_frame_parser
  import motion_command_pkg::*;
#(
  parameter int IDLE_CYC   = (`IDLE_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PROG_DEPTH = `PROG_DEPTH_DEF,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    rst_n,
  // Received bytes
  input  wire logic    rxValid,
  output logic         rxReady,
  input  wire byte_t   rxData,
  input  wire can_id_t canRxId,
  // Link setup
  input  wire logic    canMode,
  input  wire byte_t   moduleAddr,
  input  wire byte_t   replyAddr,
  input  wire can_id_t moduleCanId,
  input  wire can_id_t replyCanId,
  // Reply bytes
  output logic         txValid,
  input  wire logic    txReady,
  output byte_t        txData,
  output logic         txLast,
  output can_id_t      txCanId,
  output logic         busDriveEn,
  // Command executor
  output logic         cmdValid,
  output byte_t        cmdNum,
  output byte_t        cmdType,
  output byte_t        cmdBank,
  output logic [31:0]  cmdValue,
  input  wire logic    doneValid,
  input  wire status_e doneStatus,
  input  wire logic [31:0] doneValue,
  // Stored program
  input  wire logic    storeMode,
  input  wire logic    runStart,
  input  wire logic    runStop,
  output logic         running
);
  localparam int PW = $clog2(PROG_DEPTH) + 1;
  localparam int IW = $clog2(IDLE_CYC + 1);

  logic [1:0] rstPipe_ff;
  logic       rstN;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstN = rstPipe_ff[1];

  // Receive FIFO: the identifier rides with each byte so matching sees the
  // identifier of the frame, not whatever is on the port when it drains
  byte_stream_if #(.W(FIFO_W)) wrIf ();
  byte_stream_if #(.W(FIFO_W)) rdIf ();

  assign wrIf.valid = rxValid;
  assign wrIf.data  = {canRxId, rxData};
  assign rxReady    = wrIf.ready;

  byte_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock (clock),
    .rstN  (rstN),
    .wr    (wrIf.snk),
    .rd    (rdIf.src)
  );

  logic [55:0] progMem [PROG_DEPTH];

  state_e      state_ff, nxt_state;
  logic [3:0]  pos_ff, nxt_pos, txPos_ff, nxt_txPos;
  byte_t       sum_ff, nxt_sum, txSum_ff, nxt_txSum, addr_ff, nxt_addr;
  byte_t       txData_ff, nxt_txData, cmdNum_ff, nxt_cmdNum;
  byte_t       cmdType_ff, nxt_cmdType, cmdBank_ff, nxt_cmdBank;
  logic [31:0] cmdValue_ff, nxt_cmdValue, repVal_ff, nxt_repVal;
  status_e     status_ff, nxt_status;
  can_id_t     canId_ff, nxt_canId, txCanId_ff, nxt_txCanId;
  logic [IW-1:0] idle_ff, nxt_idle;
  logic [PW-1:0] progLen_ff, nxt_progLen, pc_ff, nxt_pc;
  logic [3:0]  firstPos, lastPos;
  logic        take, frameEnd, match, chkOk, goReply, memWe, timeout;
  byte_t       inByte;
  logic [55:0] memWord, loadWord;

  function automatic byte_t replyByte(input logic [3:0] p, input byte_t sum,
                                      input byte_t rAddr, input byte_t mAddr,
                                      input status_e st, input byte_t num,
                                      input logic [31:0] val);
    byte_t b;
    b = sum;
    case (p)
      `POS_ADDR:       b = rAddr;
      `POS_CMD:        b = mAddr;
      `POS_REP_STATUS: b = st;
      `POS_BANK:       b = num;
      `POS_VAL_FIRST:  b = val[31:24];
      `POS_VAL_SECOND: b = val[23:16];
      `POS_VAL_THIRD:  b = val[15:8];
      `POS_VAL_LAST:   b = val[7:0];
      default:         b = sum;
    endcase
    return b;
  endfunction : replyByte

  always_comb begin
    // Serial frames span positions 0..8, CAN frames only the core 1..7
    firstPos     = canMode ? `POS_CMD : `POS_ADDR;
    lastPos      = canMode ? `POS_VAL_LAST : `POS_CHK;
    nxt_state    = state_ff;
    nxt_pos      = pos_ff;
    nxt_sum      = sum_ff;
    nxt_addr     = addr_ff;
    nxt_canId    = canId_ff;
    nxt_cmdNum   = cmdNum_ff;
    nxt_cmdType  = cmdType_ff;
    nxt_cmdBank  = cmdBank_ff;
    nxt_cmdValue = cmdValue_ff;
    nxt_status   = status_ff;
    nxt_repVal   = repVal_ff;
    nxt_txPos    = txPos_ff;
    nxt_txSum    = txSum_ff;
    nxt_txData   = txData_ff;
    nxt_txCanId  = txCanId_ff;
    nxt_idle     = idle_ff;
    nxt_progLen  = progLen_ff;
    nxt_pc       = pc_ff;
    take         = 1'b0;
    frameEnd     = 1'b0;
    goReply      = 1'b0;
    memWe        = 1'b0;
    timeout      = 1'b0;
    inByte       = rdIf.data[7:0];
    memWord      = '0;
    loadWord     = progMem[pc_ff[PW-2:0]];
    match        = canMode ? (canId_ff == moduleCanId) : (addr_ff == moduleAddr);
    chkOk        = canMode || (inByte == sum_ff);
    case (state_ff)
      S_RECV: begin
        take = rdIf.valid;
        if (rdIf.valid) begin
          nxt_idle = '0;
          nxt_sum  = byte_t'(sum_ff + inByte);
          nxt_pos  = 4'(pos_ff + 1'b1);
          if (pos_ff == firstPos) begin
            nxt_canId = rdIf.data[FIFO_W-1:8];
          end
          case (pos_ff)
            `POS_ADDR: nxt_addr    = inByte;
            `POS_CMD:  nxt_cmdNum  = inByte;
            `POS_TYPE: nxt_cmdType = inByte;
            `POS_BANK: nxt_cmdBank = inByte;
            `POS_CHK:  nxt_cmdValue = cmdValue_ff;
            default:   nxt_cmdValue = {cmdValue_ff[23:0], inByte};
          endcase
          if (pos_ff == lastPos) begin
            frameEnd = 1'b1;
            nxt_pos  = firstPos;
            nxt_sum  = '0;
            memWord  = {nxt_cmdNum, nxt_cmdType, nxt_cmdBank, nxt_cmdValue};
            // Foreign frames are dropped silently; the bus stays quiet
            if (!match) begin
              nxt_state = S_RECV;
            end else if (!chkOk) begin
              nxt_status = ST_BAD_CHECKSUM;
              nxt_repVal = nxt_cmdValue;
              goReply    = 1'b1;
            end else if (storeMode) begin
              memWe      = (progLen_ff != PW'(PROG_DEPTH));
              nxt_status = memWe ? ST_STORED : ST_BAD_VALUE;
              nxt_repVal = nxt_cmdValue;
              goReply    = 1'b1;
            end else begin
              nxt_state = S_EXEC;
            end
          end
        end else if (pos_ff != firstPos) begin
          nxt_idle = IW'(idle_ff + 1'b1);
          if (idle_ff == IW'(IDLE_CYC - 1)) begin
            timeout  = 1'b1;
            nxt_pos  = firstPos;
            nxt_sum  = '0;
            nxt_idle = '0;
          end
        end else if (runStart && progLen_ff != '0) begin
          nxt_state = S_RUN;
          nxt_pc    = '0;
          {nxt_cmdNum, nxt_cmdType, nxt_cmdBank, nxt_cmdValue} = progMem[0];
        end
      end
      S_EXEC: begin
        if (doneValid) begin
          nxt_status = doneStatus;
          nxt_repVal = doneValue;
          goReply    = 1'b1;
        end
      end
      S_REPLY: begin
        if (txReady) begin
          nxt_txSum = byte_t'(txSum_ff + txData_ff);
          if (txPos_ff == lastPos) begin
            nxt_state = S_RECV;
          end else begin
            nxt_txPos  = 4'(txPos_ff + 1'b1);
            nxt_txData = replyByte(nxt_txPos, nxt_txSum, replyAddr, moduleAddr,
                                   status_ff, cmdNum_ff, repVal_ff);
          end
        end
      end
      S_RUN: begin
        // Stored commands run without replies; the host port waits in the FIFO
        if (doneValid) begin
          if (runStop || pc_ff == PW'(progLen_ff - 1'b1)) begin
            nxt_state = S_RECV;
          end else begin
            nxt_pc   = PW'(pc_ff + 1'b1);
            loadWord = progMem[nxt_pc[PW-2:0]];
            {nxt_cmdNum, nxt_cmdType, nxt_cmdBank, nxt_cmdValue} = loadWord;
          end
        end
      end
      default: begin
        nxt_state = S_RECV;
      end
    endcase
    if (memWe) begin
      nxt_progLen = PW'(progLen_ff + 1'b1);
    end
    if (goReply) begin
      nxt_state   = S_REPLY;
      nxt_txPos   = firstPos;
      nxt_txSum   = '0;
      nxt_txCanId = replyCanId;
      nxt_txData  = replyByte(firstPos, 8'h00, replyAddr, moduleAddr,
                              nxt_status, nxt_cmdNum, nxt_repVal);
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_ff    <= S_RECV;
      pos_ff      <= `POS_ADDR;
      sum_ff      <= '0;
      addr_ff     <= '0;
      canId_ff    <= '0;
      cmdNum_ff   <= '0;
      cmdType_ff  <= '0;
      cmdBank_ff  <= '0;
      cmdValue_ff <= '0;
      status_ff   <= ST_OK;
      repVal_ff   <= '0;
      txPos_ff    <= `POS_ADDR;
      txSum_ff    <= '0;
      txData_ff   <= '0;
      txCanId_ff  <= '0;
      idle_ff     <= '0;
      progLen_ff  <= '0;
      pc_ff       <= '0;
    end else begin
      state_ff    <= nxt_state;
      pos_ff      <= nxt_pos;
      sum_ff      <= nxt_sum;
      addr_ff     <= nxt_addr;
      canId_ff    <= nxt_canId;
      cmdNum_ff   <= nxt_cmdNum;
      cmdType_ff  <= nxt_cmdType;
      cmdBank_ff  <= nxt_cmdBank;
      cmdValue_ff <= nxt_cmdValue;
      status_ff   <= nxt_status;
      repVal_ff   <= nxt_repVal;
      txPos_ff    <= nxt_txPos;
      txSum_ff    <= nxt_txSum;
      txData_ff   <= nxt_txData;
      txCanId_ff  <= nxt_txCanId;
      idle_ff     <= nxt_idle;
      progLen_ff  <= nxt_progLen;
      pc_ff       <= nxt_pc;
    end
  end

  always_ff @(posedge clock) begin
    if (memWe) begin
      progMem[progLen_ff[PW-2:0]] <= memWord;
    end
  end

  assign rdIf.ready = take;
  assign txValid    = (state_ff == S_REPLY);
  assign busDriveEn = (state_ff == S_REPLY);
  assign txData     = txData_ff;
  assign txLast     = txValid && (txPos_ff == lastPos);
  assign txCanId    = txCanId_ff;
  assign cmdValid   = (state_ff == S_EXEC) || (state_ff == S_RUN);
  assign cmdNum     = cmdNum_ff;
  assign cmdType    = cmdType_ff;
  assign cmdBank    = cmdBank_ff;
  assign cmdValue   = cmdValue_ff;
  assign running    = (state_ff == S_RUN);

  // Bytes sent in the current reply, for the length check only
  logic [3:0] txCnt_ff;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      txCnt_ff <= '0;
    end else if (!txValid) begin
      txCnt_ff <= '0;
    end else if (txReady) begin
      txCnt_ff <= 4'(txCnt_ff + 1'b1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  reply_after_exec_a: assert property (
    (state_ff == S_EXEC && doneValid) |=> txValid && status_ff == $past(doneStatus))
    else $error("No reply after command done");
  reply_has_cause_a: assert property (
    $rose(busDriveEn) |-> $past(doneValid && state_ff == S_EXEC) || $past(frameEnd))
    else $error("Bus driven without a received command");
  exec_before_reply_a: assert property (
    (frameEnd && match && chkOk && !storeMode) |=> cmdValid && !txValid)
    else $error("Reply before command executed");
  bad_checksum_a: assert property (
    (frameEnd && !canMode && match && inByte != sum_ff)
      |=> txValid && status_ff == ST_BAD_CHECKSUM)
    else $error("Checksum error not reported");
  reply_length_a: assert property (
    (txValid && txReady && txLast) |-> txCnt_ff == (canMode ? 4'h6 : 4'h8))
    else $error("Reply byte count wrong");
  value_msb_first_a: assert property (
    (txValid && txPos_ff == `POS_VAL_FIRST) |-> txData == repVal_ff[31:24])
    else $error("Reply value not MSB first");
  can_reply_head_a: assert property (
    ($rose(txValid) && canMode) |-> txData == moduleAddr && txCanId == replyCanId)
    else $error("CAN reply header wrong");
  foreign_dropped_a: assert property (
    (frameEnd && !match) |=> !txValid [*2])
    else $error("Foreign frame answered");
  idle_resync_a: assert property (
    timeout |=> pos_ff == firstPos && sum_ff == 8'h00)
    else $error("Idle timeout did not restart frame");
  store_no_exec_a: assert property (
    (frameEnd && match && chkOk && storeMode) |=> !cmdValid && txValid)
    else $error("Stored command was executed");

  serial_reply_c: cover property (txLast && txReady && !canMode && status_ff == ST_OK);
  can_reply_c: cover property (txLast && txReady && canMode);
  program_run_c: cover property (running && doneValid ##1 !running);
  fifo_full_c: cover property (!rxReady && rxValid);
endmodule : motion_command_frame_parser
`default_nettype wire

// file: verif/host_link_model.sv
// Host-side model: sends command frames and takes reply bytes.
// Assumes one clock shared with the parser; slow makes the host stall replies.
`timescale 1ns/1ps
`default_nettype none
module host_link_model
  import motion_command_pkg::*;
(
  // Clock
  input  wire logic    clock,
  // Command bytes
  output var logic     rxValid,
  input  wire logic    rxReady,
  output var byte_t    rxData,
  output var can_id_t  canRxId,
  // Reply bytes
  input  wire logic    txValid,
  output var logic     txReady,
  input  wire byte_t   txData,
  input  wire logic    txLast
);
  byte_t got[$];
  int    replyCount = 0;
  int    accepted   = 0;
  int    cyc        = 0;
  logic  slow       = 1'b0;

  initial begin
    rxValid = 1'b0;
    rxData  = 8'hA5;
    canRxId = '0;
    txReady = 1'b0;
  end

  // Reply bytes count on the handshake edge only
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txData);
      if (txLast === 1'b1)
        replyCount <= replyCount + 1;
    end
    txReady <= !slow || (cyc % 3 == 0);
  end

  // Back to back bytes, each held until the edge that samples ready
  task automatic send(input byte_t q[$], input can_id_t id);
    @(posedge clock);
    canRxId <= id;
    foreach (q[i]) begin
      rxValid <= 1'b1;
      rxData  <= q[i];
      do @(posedge clock); while (rxReady !== 1'b1);
      accepted++;
    end
    rxValid <= 1'b0;
    // Released line shows no stale byte
    rxData  <= ~q[q.size()-1];
  endtask : send

  // Serial adds address and sum, CAN sends the core only
  task automatic frame(input byte_t a, c, t, b, input logic [31:0] v, input logic can,
                       input can_id_t id, input logic bad, input int cut);
    byte_t q[$];
    byte_t s;
    q = {a, c, t, b, v[31:24], v[23:16], v[15:8], v[7:0]};
    s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(bad ? s + 8'h01 : s);
    if (can)
      q = q[1:7];
    while (q.size() > cut) void'(q.pop_back());
    send(q, id);
  endtask : frame
endmodule : host_link_model
`default_nettype wire

// file: verif/motion_command_frame_parser_tb_top.sv
// Self-checking bench for the command frame parser.
// Assumes the host model drives the byte side; the bench acts as executor.
`timescale 1ns/1ps
`default_nettype none
module motion_command_frame_parser_tb_top;
  import motion_command_pkg::*;
  localparam int IDLE = 20;
  logic clock, rst_n, canMode, storeMode, runStart, runStop, doneValid;
  logic rxValid, rxReady, txValid, txReady, txLast, busDriveEn, cmdValid, running;
  byte_t rxData, txData, moduleAddr, replyAddr, cmdNum, cmdType, cmdBank, c, t, b;
  can_id_t canRxId, moduleCanId, replyCanId, txCanId;
  status_e doneStatus;
  logic [31:0] doneValue, cmdValue, v, seed = 32'd76648;
  int badCount = 0, checkCount = 0, replies = 0, cmdRises = 0, cycles = 0;
  logic cmdPrev = 1'b0;
  int exp[$];

  motion_command_frame_parser #(.IDLE_CYC(IDLE)) motion_command_frame_parser_i (
    .clock(clock), .rst_n(rst_n), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .canRxId(canRxId), .canMode(canMode), .moduleAddr(moduleAddr), .replyAddr(replyAddr),
    .moduleCanId(moduleCanId), .replyCanId(replyCanId), .txValid(txValid),
    .txReady(txReady), .txData(txData), .txLast(txLast), .txCanId(txCanId),
    .busDriveEn(busDriveEn), .cmdValid(cmdValid), .cmdNum(cmdNum), .cmdType(cmdType),
    .cmdBank(cmdBank), .cmdValue(cmdValue), .doneValid(doneValid),
    .doneStatus(doneStatus), .doneValue(doneValue), .storeMode(storeMode),
    .runStart(runStart), .runStop(runStop), .running(running));

  host_link_model host_link_model_i (
    .clock(clock), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .canRxId(canRxId), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txLast(txLast));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checkCount++;
    if (seen !== want) begin
      badCount++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Driver enable must track the reply exactly; CAN replies carry their id
  always @(negedge clock) begin
    if (rst_n === 1'b1) begin
      check(busDriveEn, txValid);
      if (canMode && txValid === 1'b1)
        check(txCanId, replyCanId);
    end
  end

  always @(posedge clock) begin
    cmdPrev <= cmdValid;
    if (cmdValid === 1'b1 && cmdPrev !== 1'b1)
      cmdRises <= cmdRises + 1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      badCount++;
      conclude();
    end
  end

  task automatic pick();
    logic [31:0] r;
    r = rnd();
    c = r[7:0];
    t = r[15:8];
    b = r[23:16];
    v = rnd();
  endtask : pick

  task automatic send(input byte_t a, input can_id_t id, input logic bad, input int cut);
    host_link_model_i.frame(a, c, t, b, v, canMode, id, bad, cut);
  endtask : send

  task automatic execute(input status_e st, input logic [31:0] rv, input int lat);
    int n;
    n = 0;
    while (cmdValid !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(cmdNum, c);
    check(cmdType, t);
    check(cmdBank, b);
    check(cmdValue, v);
    repeat (lat) @(posedge clock);
    check(txValid, 1'b0);
    doneValid  <= 1'b1;
    doneStatus <= st;
    doneValue  <= rv;
    @(posedge clock);
    doneValid  <= 1'b0;
  endtask : execute

  // Reference reply built from the frame layout; all=0 checks length and status only
  task automatic expect_reply(input int st, input logic [31:0] rv, input logic all);
    int s, n, stPos;
    exp = {replyAddr, moduleAddr, st, c, rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
    s = 0;
    foreach (exp[i]) s += exp[i];
    exp.push_back(s % 256);
    if (canMode)
      exp = exp[1:7];
    stPos = canMode ? 1 : 2;
    n = 0;
    while (host_link_model_i.replyCount == replies && n < 500) begin
      @(posedge clock);
      n++;
    end
    replies++;
    check(host_link_model_i.got.size(), exp.size());
    foreach (exp[i])
      if (all || i == stPos)
        check(host_link_model_i.got[i], exp[i]);
    host_link_model_i.got.delete();
  endtask : expect_reply

  task automatic expect_quiet(input int rises);
    repeat (60) @(posedge clock);
    check(cmdRises, rises);
    check(host_link_model_i.replyCount, replies);
  endtask : expect_quiet

  initial begin
    logic [31:0] r, rv;
    int acc;
    status_e sts[4];
    int lats[4];
    sts  = '{ST_OK, ST_BAD_COMMAND, ST_BAD_TYPE, ST_BAD_VALUE};
    lats = '{0, 1, 5, 17};
    rst_n = 1'b0;
    canMode = 1'b0;
    storeMode = 1'b0;
    runStart = 1'b0;
    runStop = 1'b0;
    doneValid = 1'b0;
    doneStatus = ST_OK;
    doneValue = '0;
    r = rnd();
    moduleAddr = r[7:0];
    replyAddr = r[15:8];
    moduleCanId = r[26:16];
    replyCanId = ~r[26:16];
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    // Host waits for each reply before the next command
    foreach (sts[i]) begin
      host_link_model_i.slow = (i > 1);
      pick();
      rv = rnd();
      send(moduleAddr, moduleCanId, 1'b0, 9);
      execute(sts[i], rv, lats[i]);
      expect_reply(sts[i], rv, 1'b1);
    end
    $display("test status codes done");
    pick();
    send(moduleAddr, moduleCanId, 1'b1, 9);
    expect_reply(ST_BAD_CHECKSUM, v, 1'b1);
    expect_quiet(cmdRises);
    send(moduleAddr ^ 8'h01, moduleCanId, 1'b0, 9);
    expect_quiet(cmdRises);
    $display("test checksum and address done");
    // A stalled partial frame is dropped, the next frame parses whole
    pick();
    send(moduleAddr, moduleCanId, 1'b0, 4);
    repeat (IDLE * 2) @(posedge clock);
    pick();
    rv = rnd();
    send(moduleAddr, moduleCanId, 1'b0, 9);
    execute(ST_OK, rv, 3);
    expect_reply(ST_OK, rv, 1'b1);
    $display("test idle timeout done");
    // Host breaks the wait rule on purpose to fill the buffer during execution
    pick();
    rv = rnd();
    send(moduleAddr, moduleCanId, 1'b0, 9);
    acc = host_link_model_i.accepted;
    fork
      begin
        send(moduleAddr ^ 8'h01, moduleCanId, 1'b0, 9);
        send(moduleAddr ^ 8'h01, moduleCanId, 1'b0, 9);
      end
    join_none
    repeat (60) @(posedge clock);
    check(host_link_model_i.accepted - acc, 16);
    check(rxReady, 1'b0);
    execute(ST_OK, rv, 0);
    expect_reply(ST_OK, rv, 1'b1);
    wait fork;
    expect_quiet(cmdRises);
    $display("test buffer full done");
    // A mode change between frames leaves the position off the new start; the idle timeout realigns the receiver
    canMode <= 1'b1;
    repeat (IDLE + 5) @(posedge clock);
    pick();
    rv = rnd();
    send(moduleAddr, moduleCanId, 1'b0, 7);
    execute(ST_OK, rv, 2);
    expect_reply(ST_OK, rv, 1'b1);
    send(moduleAddr, moduleCanId ^ 11'h001, 1'b0, 7);
    expect_quiet(cmdRises);
    canMode <= 1'b0;
    repeat (IDLE + 5) @(posedge clock);
    $display("test can done");
    // Stored command replays later with no reply
    storeMode <= 1'b1;
    pick();
    send(moduleAddr, moduleCanId, 1'b0, 9);
    expect_reply(ST_STORED, v, 1'b1);
    expect_quiet(cmdRises);
    storeMode <= 1'b0;
    runStart <= 1'b1;
    runStop <= 1'b1;
    @(posedge clock);
    runStart <= 1'b0;
    @(posedge clock);
    check(running, 1'b1);
    execute(ST_OK, rnd(), 2);
    repeat (10) @(posedge clock);
    check(running, 1'b0);
    check(host_link_model_i.replyCount, replies);
    runStop <= 1'b0;
    $display("test stored program done");
    conclude();
  end
endmodule : motion_command_frame_parser_tb_top
`default_nettype wire
